// file: testbench/scp_host.sv
// host model for the serial link
`timescale 1ns/1ps
module scp_host (
    output reg  cs_n = 1'b1,
    output reg  sck = 1'b0,
    output reg  hd = 1'b0,
    input  wire rx
);
    reg [7:0] rd;
    // bits move on sck fall; read data bits leave the line toggling
    task xfer(input [23:0] f, input integer n, input sel);
        cs_n = !sel;
        for (int i = 23; i > 23 - n; i--) begin
            hd = (f[23] && i < 8) ? !hd : f[i] && (i < 21 || i > 22);
            #40 sck = 1'b1;
            rd = {rd[6:0], rx};
            #40 sck = 1'b0;
        end
        #40 cs_n = 1'b1;
        #120;
    endtask
endmodule // scp_host

// file: testbench/scp_port_props.sv
// checker on the port outputs
`timescale 1ns/1ps
module scp_port_props (
    input wire        sys_clk,
    input wire        nrst,
    input wire        cs_n_pin,
    input wire        sck_pin,
    input wire        serial_data_in,
    input wire        four_wire_en,
    input wire        sdio_out,
    input wire        sdio_oe,
    input wire        rdbk_out,
    input wire        wr_strobe,
    input wire [12:0] wr_addr,
    input wire [7:0]  wr_data
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_strobe_pulse: assert property (wr_strobe |=> !wr_strobe) else $error("long strobe");
    a_strobe_frame: assert property (wr_strobe |-> cs_n_pin && !$past(cs_n_pin, 8)) else $error("stray");
    a_idle_quiet: assert property (cs_n_pin [*8] |=> !wr_strobe) else $error("idle commit");
    a_hdr_undriven: assert property ($fell(cs_n_pin) |=> !sdio_oe [*8]) else $error("early");
    a_idle_undriven: assert property (cs_n_pin [*6] |-> !sdio_oe) else $error("idle drive");
    a_four_undriven: assert property (four_wire_en && $past(four_wire_en) |-> !sdio_oe) else $error("4w");
    a_sdo_stands: assert property ($rose(sck_pin) |=> $stable(sdio_out) [*2]) else $error("sdio");
    a_rdbk_stands: assert property ($rose(sck_pin) |=> $stable(rdbk_out) [*2]) else $error("rdbk");
    a_sdo_after_fall: assert property ($changed(sdio_out) |-> !sck_pin && $past(sck_pin, 4))
        else $error("sdio launch");
    a_rdbk_after_fall: assert property ($changed(rdbk_out) |-> !sck_pin && $past(sck_pin, 4))
        else $error("rdbk launch");
    c_write: cover property (wr_strobe);
    c_read: cover property (sdio_oe);
    c_read_4w: cover property (four_wire_en && $changed(rdbk_out));
    c_write_top: cover property (wr_strobe && wr_addr == 13'h1FFF && wr_data == 8'hA5);
endmodule // scp_port_props

// file: testbench/testbench.sv
// bench for the serial configuration port
`timescale 1ns/1ps
module testbench;
    reg sys_clk = 1'b0, nrst = 1'b0, four_wire_en = 1'b0;
    wire cs_n_pin, sck_pin, hd, sdio_out, sdio_oe, rdbk_out, wr_strobe;
    wire [12:0] wr_addr;
    wire [7:0] wr_data;
    wire line = sdio_oe ? sdio_out : hd;
    integer mismatches = 0, checks = 0, cyc = 0, nstb = 0, n0;
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) nstb <= nstb + (wr_strobe === 1'b1);
    always @(posedge sys_clk) if (++cyc == 5000) wrap_up(1'b1);
    scp_host i_host (.cs_n(cs_n_pin), .sck(sck_pin), .hd(hd), .rx(four_wire_en ? rdbk_out : line));
    scp_port i_dut (
        .sys_clk        (sys_clk),
        .nrst           (nrst),
        .cs_n_pin       (cs_n_pin),
        .sck_pin        (sck_pin),
        .serial_data_in (line),
        .four_wire_en   (four_wire_en),
        .sdio_out       (sdio_out),
        .sdio_oe        (sdio_oe),
        .rdbk_out       (rdbk_out),
        .wr_strobe      (wr_strobe),
        .wr_addr        (wr_addr),
        .wr_data        (wr_data)
    );
    task check(input [31:0] seen, input [31:0] exp);
        checks++;
        mismatches += (seen !== exp);
        if (seen !== exp) $display("wrong value at %0t: %h not %h", $time, seen, exp);
    endtask
    // scenarios count commit strobes
    task t_write(input [12:0] a, input [7:0] d);
        n0 = nstb;
        i_host.xfer({3'h0, a, d}, 24, 1'b1);
        check({wr_addr, wr_data, 8'(nstb - n0)}, {a, d, 8'h01});
        $display("write done");
    endtask
    task t_read(input fw, input [12:0] a, input [7:0] d);
        four_wire_en = fw;
        n0 = nstb;
        i_host.xfer({3'h4, a, 8'h00}, 24, 1'b1);
        check({i_host.rd, 8'(nstb - n0)}, {d, 8'h00});
        $display("read done");
    endtask
    task t_refuse;
        n0 = nstb;
        i_host.xfer(24'h00FFFF, 20, 1'b1);
        i_host.xfer(24'h00FFFF, 24, 1'b0);
        check({wr_addr, wr_data, 8'(nstb - n0)}, {13'h0000, 8'h5A, 8'h00});
        $display("refuse done");
    endtask
    task wrap_up(input hung);
        mismatches += hung;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        nrst = #80 1'b1;
        #24;
        t_write(13'h1FFF, 8'hA5);
        t_write(13'h0000, 8'h5A);
        t_read(1'b0, 13'h1FFF, 8'hA5);
        t_read(1'b1, 13'h0000, 8'h5A);
        t_refuse;
        wrap_up(1'b0);
    end
endmodule // testbench
bind scp_port scp_port_props i_props (
    .sys_clk        (sys_clk),
    .nrst           (nrst),
    .cs_n_pin       (cs_n_pin),
    .sck_pin        (sck_pin),
    .serial_data_in (serial_data_in),
    .four_wire_en   (four_wire_en),
    .sdio_out       (sdio_out),
    .sdio_oe        (sdio_oe),
    .rdbk_out       (rdbk_out),
    .wr_strobe      (wr_strobe),
    .wr_addr        (wr_addr),
    .wr_data        (wr_data)
);

// file: verilog/scp_defines.vh
// constants for the serial configuration port
// How it works
// - data line is sampled into the shift register on each serial clock rise while chip-select is low, except a rise seen in the cycle chip-select falls
// - chip-select rising after a full write frame copies shift register into the addressed config register
// - direction bit zero means write, one means read
// - read bits launch 16 to 24 ns after serial clock fall, so not always within the 20 ns valid time
// - four-wire mode drives readback output with identical edge timing
`ifndef SCP_DEFINES_VH
`define SCP_DEFINES_VH
// frame layout: rw, length_select_hi, length_select_lo, address, data
`define SCP_ADDR_W        13
`define SCP_DATA_W        8
`define SCP_HDR_BITS      16
`define SCP_FRAME_BITS    24
`define SCP_CNT_W         5
`define SCP_HDR_LAST      5'h0F
`define SCP_FRAME_FULL    5'h18
`define SCP_RW_POS        15
`define SCP_ADDR_HI       12
// readback valid time and its cycle count at the system clock rate
`define SCP_TDV_NS        20
`define SCP_CLK_NS        8
`define SCP_TDV_CYC       ((`SCP_TDV_NS) / (`SCP_CLK_NS))
`define SCP_REG_RESET     8'h00
// pin gathering for the synchroniser loop; chip-select idles high
`define SCP_NUM_PINS      3
`define SCP_PIN_CS        2
`define SCP_PIN_SCK       1
`define SCP_PIN_SDI       0
`define SCP_PIN_IDLE      3'h4
`endif

// file: verilog/scp_port.v
// serial configuration port: shift register, config array and readback driver
`timescale 1ns/1ps
`include "scp_defines.vh"
module scp_port #(
    parameter NUM_REGS = 8192
) (
    sys_clk,
    nrst,
    cs_n_pin,
    sck_pin,
    serial_data_in,
    four_wire_en,
    sdio_out,
    sdio_oe,
    rdbk_out,
    wr_strobe,
    wr_addr,
    wr_data
);
    input  wire                     sys_clk;
    input  wire                     nrst;
    input  wire                     cs_n_pin;
    input  wire                     sck_pin;
    input  wire                     serial_data_in;
    input  wire                     four_wire_en;
    output reg                      sdio_out;
    output reg                      sdio_oe;
    output reg                      rdbk_out;
    output reg                      wr_strobe;
    output reg  [`SCP_ADDR_W-1:0]   wr_addr;
    output reg  [`SCP_DATA_W-1:0]   wr_data;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers; each pin resets to its idle level so that
    // no false edge is seen while the first stages fill after reset
    localparam [`SCP_NUM_PINS-1:0] PIN_IDLE = `SCP_PIN_IDLE;

    wire [`SCP_NUM_PINS-1:0] pin_raw;
    wire [`SCP_NUM_PINS-1:0] pin_sync;
    wire                     cs_n_s;
    wire                     sck_s;
    wire                     sdi_s;

    // gather the pins so one loop can synchronise them all
    assign pin_raw[`SCP_PIN_CS]  = cs_n_pin;
    assign pin_raw[`SCP_PIN_SCK] = sck_pin;
    assign pin_raw[`SCP_PIN_SDI] = serial_data_in;

    genvar g;
    generate
        for (g = 0; g < `SCP_NUM_PINS; g = g + 1) begin : g_sync
            scp_sync #(
                .RST_VAL  (PIN_IDLE[g])
            ) u_sync (
                .sys_clk  (sys_clk),
                .nrst     (nrst),
                .async_in (pin_raw[g]),
                .sync_out (pin_sync[g])
            );
        end
    endgenerate

    // synchronised levels by name
    assign cs_n_s = pin_sync[`SCP_PIN_CS];
    assign sck_s  = pin_sync[`SCP_PIN_SCK];
    assign sdi_s  = pin_sync[`SCP_PIN_SDI];

    ////////////////////////////////////////////////////////////////////////
    // edge detection on synchronised levels
    reg cs_n_d_reg;
    reg sck_d_reg;

    // chip-select idles high, so reset the delayed copy high
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cs_n_d_reg <= 1'b1;
            sck_d_reg  <= 1'b0;
        end else begin
            cs_n_d_reg <= cs_n_s;
            sck_d_reg  <= sck_s;
        end
    end

    wire sck_rise = sck_s & ~sck_d_reg & ~cs_n_s;
    wire sck_fall = ~sck_s & sck_d_reg & ~cs_n_s;
    wire cs_rise  = cs_n_s & ~cs_n_d_reg;
    wire cs_fall  = ~cs_n_s & cs_n_d_reg;

    ////////////////////////////////////////////////////////////////////////
    // configuration storage
    reg [`SCP_DATA_W-1:0] cfg_mem [0:NUM_REGS-1];

    ////////////////////////////////////////////////////////////////////////
    // shift register and frame state
    reg [`SCP_FRAME_BITS-1:0] shift_reg;
    reg [`SCP_CNT_W-1:0]      bit_cnt_reg;
    reg                       rd_mode_reg;
    reg [`SCP_DATA_W-1:0]     rd_shift_reg;

    wire [`SCP_FRAME_BITS-1:0] shift_next = {shift_reg[`SCP_FRAME_BITS-2:0], sdi_s};
    wire [`SCP_ADDR_W-1:0]     hdr_addr   = shift_next[`SCP_ADDR_HI:0];
    wire                       hdr_done   = (bit_cnt_reg == `SCP_HDR_LAST);
    wire                       frame_full = (bit_cnt_reg == `SCP_FRAME_FULL);

    // next-state values of the counter, direction and readback shifter
    reg [`SCP_CNT_W-1:0]  bit_cnt_next;
    reg                   rd_mode_next;
    reg [`SCP_DATA_W-1:0] rd_shift_next;

    // array word for the addressed register, taken when the header ends
    wire [`SCP_DATA_W-1:0] rd_word = cfg_mem[hdr_addr];

    // a chip-select fall starts a new frame and wins over a coincident rise
    always @* begin
        bit_cnt_next  = bit_cnt_reg;
        rd_mode_next  = rd_mode_reg;
        rd_shift_next = rd_shift_reg;
        if (cs_fall) begin
            bit_cnt_next = {`SCP_CNT_W{1'b0}};
            rd_mode_next = 1'b0;
        end else if (sck_rise) begin
            // counter saturates so an overlong frame keeps its last bits
            if (!frame_full) begin
                bit_cnt_next = bit_cnt_reg + 1'b1;
            end
            if (hdr_done) begin
                rd_mode_next  = shift_next[`SCP_RW_POS];
                rd_shift_next = rd_word;
            end else if (rd_mode_reg) begin
                rd_shift_next = {rd_shift_reg[`SCP_DATA_W-2:0], 1'b0};
            end
        end
    end

    // shift register moves only on a sampled serial clock rise
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            shift_reg    <= {`SCP_FRAME_BITS{1'b0}};
            bit_cnt_reg  <= {`SCP_CNT_W{1'b0}};
            rd_mode_reg  <= 1'b0;
            rd_shift_reg <= `SCP_REG_RESET;
        end else begin
            if (sck_rise && !cs_fall) begin
                shift_reg <= shift_next;
            end
            bit_cnt_reg  <= bit_cnt_next;
            rd_mode_reg  <= rd_mode_next;
            rd_shift_reg <= rd_shift_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // field decoders of a completed frame, shared by the array write and
    // the write notification so the two can never disagree
    function [`SCP_ADDR_W-1:0] frame_addr;
        input [`SCP_FRAME_BITS-1:0] frame;
        begin
            frame_addr = frame[`SCP_DATA_W + `SCP_ADDR_HI:`SCP_DATA_W];
        end
    endfunction

    function [`SCP_DATA_W-1:0] frame_data;
        input [`SCP_FRAME_BITS-1:0] frame;
        begin
            frame_data = frame[`SCP_DATA_W-1:0];
        end
    endfunction

    // direction bit of a completed frame, one means read
    function frame_is_read;
        input [`SCP_FRAME_BITS-1:0] frame;
        begin
            frame_is_read = frame[`SCP_DATA_W + `SCP_RW_POS];
        end
    endfunction

    // commit on chip-select rise, writes only, full frame only; a cut
    // frame leaves the array and the notification alone
    wire commit = cs_rise & frame_full & ~frame_is_read(shift_reg);

    // array write; no reset, so a register reads back only once written
    always @(posedge sys_clk) begin
        if (commit) begin
            cfg_mem[frame_addr(shift_reg)] <= frame_data(shift_reg);
        end
    end

    // write notification for the rest of the device
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wr_strobe <= 1'b0;
            wr_addr   <= {`SCP_ADDR_W{1'b0}};
            wr_data   <= `SCP_REG_RESET;
        end else begin
            wr_strobe <= commit;
            if (commit) begin
                wr_addr <= frame_addr(shift_reg);
                wr_data <= frame_data(shift_reg);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // readback launch after a serial clock fall; synchroniser and edge
    // stage put it 16 to 24 ns after the pin fall, up to 4 ns beyond the 20 ns valid
    // window at this clock rate, so the host must allow for that latency
    wire launch = sck_fall & rd_mode_reg;

    // three-wire drives the data line, four-wire the readback pin; the data
    // line is released as soon as chip-select is seen high
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sdio_out <= 1'b0;
            sdio_oe  <= 1'b0;
            rdbk_out <= 1'b0;
        end else if (cs_n_s) begin
            sdio_oe <= 1'b0;
        end else if (launch) begin
            if (four_wire_en) begin
                rdbk_out <= rd_shift_reg[`SCP_DATA_W-1];
                sdio_oe  <= 1'b0;
            end else begin
                sdio_out <= rd_shift_reg[`SCP_DATA_W-1];
                sdio_oe  <= 1'b1;
            end
        end
    end
endmodule // scp_port

// file: verilog/scp_sync.v
// two-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
module scp_sync #(
    parameter RST_VAL = 1'b0
) (
    sys_clk,
    nrst,
    async_in,
    sync_out
);
    input  wire sys_clk;
    input  wire nrst;
    input  wire async_in;
    output wire sync_out;

    reg meta_reg;
    reg sync_reg;

    // first stage feeds only the second; reset to the pin's idle level
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule // scp_sync
